// ---- inc/cnpg_defines.vh ----
// Purpose : shared constants of the configuration nvm program guard
// Assumes : included by bare name from every design file
// Notes   : definitions only
`ifndef CNPG_DEFINES_VH
`define CNPG_DEFINES_VH

// ------------------------------------------------------------
// serial port
// ------------------------------------------------------------
`define CNPG_DEV_ADDR       7'h08

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define CNPG_CFG_FIRST      8'h01
`define CNPG_CFG_LAST       8'h0A
`define CNPG_KEY_OFFSET     8'h0B
`define CNPG_CFG_BYTES      10

// ------------------------------------------------------------
// key codes and reset values
// ------------------------------------------------------------
`define CNPG_KEY_UNLOCK     8'h41
`define CNPG_KEY_PREREAD    8'h62
`define CNPG_KEY_RESET      8'h00
`define CNPG_CFG_RESET      8'h00
`define CNPG_TRIM_RESET     8'hA5
// cfg bytes reset to zero, so the column parity of the reset image is the trim byte
`define CNPG_PARITY_RESET   8'hA5

`endif

// ---- hdl/cnpg_i2c_slave.v ----
// Purpose : i2c register slave with pointer byte and auto increment
// Assumes : scl and sda pins arrive asynchronously, open-drain sda
// Notes   : port is held idle while i_enable is low
`timescale 1ns/1ps
`include "cnpg_defines.vh"

module cnpg_i2c_slave (
    input  wire       i_clk,
    input  wire       i_rst_b,
    input  wire       i_enable,
    input  wire       i_scl,
    input  wire       i_sda,
    input  wire [7:0] i_rd_data,
    output reg        o_sda_oe,
    output reg  [7:0] o_addr,
    output reg  [7:0] o_wr_data,
    output reg        o_wr_stb
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_DEV  = 3'h1;
    localparam [2:0] ST_PTR  = 3'h2;
    localparam [2:0] ST_WDAT = 3'h3;
    localparam [2:0] ST_ACK  = 3'h4;
    localparam [2:0] ST_RDAT = 3'h5;
    localparam [2:0] ST_RACK = 3'h6;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg  [1:0] scl_sync_reg;
    reg  [1:0] sda_sync_reg;
    reg        scl_prev_reg;
    reg        sda_prev_reg;
    reg  [2:0] state_reg;
    reg  [2:0] after_ack_reg;
    reg  [3:0] bit_cnt_reg;
    reg  [7:0] shift_reg;
    wire       scl_s;
    wire       sda_s;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_cond;
    wire       stop_cond;

    assign scl_s      = scl_sync_reg[1];
    assign sda_s      = sda_sync_reg[1];
    assign scl_rise   = scl_s & ~scl_prev_reg;
    assign scl_fall   = ~scl_s & scl_prev_reg;
    assign start_cond = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_cond  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], i_scl};
            sda_sync_reg <= {sda_sync_reg[0], i_sda};
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg     <= ST_IDLE;
            after_ack_reg <= ST_IDLE;
            bit_cnt_reg   <= 4'h0;
            shift_reg     <= 8'h00;
            o_sda_oe      <= 1'b0;
            o_addr        <= 8'h00;
            o_wr_data     <= 8'h00;
            o_wr_stb      <= 1'b0;
        end else begin
            o_wr_stb <= 1'b0;
            if (!i_enable || stop_cond) begin
                state_reg <= ST_IDLE;
                o_sda_oe  <= 1'b0;
            end else if (start_cond) begin
                state_reg   <= ST_DEV;
                bit_cnt_reg <= 4'h0;
                o_sda_oe    <= 1'b0;
            end else begin
                case (state_reg)
                    ST_DEV, ST_PTR, ST_WDAT: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            bit_cnt_reg <= 4'h0;
                            state_reg   <= ST_ACK;
                            o_sda_oe    <= 1'b1;
                            if (state_reg == ST_DEV) begin
                                if (shift_reg[7:1] != `CNPG_DEV_ADDR) begin
                                    state_reg <= ST_IDLE;
                                    o_sda_oe  <= 1'b0;
                                end
                                after_ack_reg <= shift_reg[0] ? ST_RDAT : ST_PTR;
                            end else if (state_reg == ST_PTR) begin
                                o_addr        <= shift_reg;
                                after_ack_reg <= ST_WDAT;
                            end else begin
                                o_wr_data     <= shift_reg;
                                o_wr_stb      <= 1'b1;
                                after_ack_reg <= ST_WDAT;
                                // marks a data byte, so its ack steps the pointer
                                bit_cnt_reg   <= 4'h1;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            state_reg   <= after_ack_reg;
                            bit_cnt_reg <= 4'h0;
                            // pointer steps once per data byte, never after the pointer byte
                            if (bit_cnt_reg == 4'h1)
                                o_addr <= o_addr + 8'h01;
                            if (after_ack_reg == ST_RDAT) begin
                                shift_reg <= i_rd_data;
                                o_sda_oe  <= ~i_rd_data[7];
                            end else begin
                                o_sda_oe <= 1'b0;
                            end
                        end
                    end
                    ST_RDAT: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_reg == 4'h8) begin
                                bit_cnt_reg <= 4'h0;
                                o_sda_oe    <= 1'b0;
                                o_addr      <= o_addr + 8'h01;
                                state_reg   <= ST_RACK;
                            end else begin
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                o_sda_oe  <= ~shift_reg[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise && sda_s) begin
                            state_reg <= ST_IDLE;
                        end else if (scl_fall) begin
                            state_reg <= ST_RDAT;
                            shift_reg <= i_rd_data;
                            o_sda_oe  <= ~i_rd_data[7];
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// ---- hdl/cnpg_top.v ----
// Purpose : nvm programming guard and parity fail-safe of the battery protector
// Assumes : one clock, async active-low reset, enable, strobe and upset pins synchronised here
// Notes   : nvm is modelled as flip-flops; the upset mask models a disturbed parity column
// Overview of operation
// - nvm cfg bytes 0x01-0x0A are written only while the key holds 0x41
// - key 0x62 makes reads of 0x01-0x0A return the stored nvm contents
// - serial clock and data are served only while the access-enable pin is high
// - a high-then-low strobe pulse commits cfg registers into nvm
// - column parity covers stored protection settings and trim data
// - parity disagreement forces discharge and charge fet drives off
`timescale 1ns/1ps
`include "cnpg_defines.vh"

module cnpg_top (
    input  wire        i_clk,
    input  wire        i_rst_b,
    input  wire        i_serial_access_enable_pin,
    input  wire        i_serial_clock_pin,
    input  wire        i_serial_data_pin,
    input  wire        i_nvm_write_strobe_pin,
    input  wire [7:0]  i_nvm_upset_mask,
    input  wire        i_discharge_request,
    input  wire        i_charge_request,
    output reg         o_serial_data_pin,
    output wire        o_serial_data_oe,
    output reg         o_discharge_fet_drive,
    output reg         o_charge_fet_drive,
    output reg         o_parity_fault,
    output reg  [79:0] o_nvm_config
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function in_cfg_range;
        input [7:0] addr;
        begin
            in_cfg_range = (addr >= `CNPG_CFG_FIRST) && (addr <= `CNPG_CFG_LAST);
        end
    endfunction

    function [7:0] column_parity;
        input [87:0] image;
        integer k;
        begin
            column_parity = 8'h00;
            for (k = 0; k < 11; k = k + 1)
                column_parity = column_parity ^ image[k*8 +: 8];
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg  [1:0]  enable_sync_reg;
    reg  [1:0]  strobe_sync_reg;
    reg  [7:0]  upset_meta_reg;
    reg  [7:0]  upset_sync_reg;
    reg         strobe_prev_reg;

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            enable_sync_reg <= 2'h0;
            strobe_sync_reg <= 2'h0;
            upset_meta_reg  <= 8'h00;
            upset_sync_reg  <= 8'h00;
            strobe_prev_reg <= 1'b0;
        end else begin
            enable_sync_reg <= {enable_sync_reg[0], i_serial_access_enable_pin};
            strobe_sync_reg <= {strobe_sync_reg[0], i_nvm_write_strobe_pin};
            upset_meta_reg  <= i_nvm_upset_mask;
            upset_sync_reg  <= upset_meta_reg;
            strobe_prev_reg <= strobe_sync_reg[1];
        end
    end

    // ------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------
    wire [7:0]  bus_addr;
    wire [7:0]  bus_wr_data;
    wire        bus_wr_stb;
    reg  [7:0]  bus_rd_data;

    cnpg_i2c_slave u_slave (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_enable  (enable_sync_reg[1]),
        .i_scl     (i_serial_clock_pin),
        .i_sda     (i_serial_data_pin),
        .i_rd_data (bus_rd_data),
        .o_sda_oe  (o_serial_data_oe),
        .o_addr    (bus_addr),
        .o_wr_data (bus_wr_data),
        .o_wr_stb  (bus_wr_stb)
    );

    // open-drain line: only ever pulls low
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            o_serial_data_pin <= 1'b0;
        else
            o_serial_data_pin <= 1'b0;
    end

    // ------------------------------------------------------------
    // key register
    // ------------------------------------------------------------
    reg  [7:0]  key_reg;
    wire        unlocked;
    wire        preread;

    assign unlocked = (key_reg == `CNPG_KEY_UNLOCK);
    assign preread  = (key_reg == `CNPG_KEY_PREREAD);

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            key_reg <= `CNPG_KEY_RESET;
        else if (bus_wr_stb && bus_addr == `CNPG_KEY_OFFSET)
            key_reg <= bus_wr_data;
    end

    // ------------------------------------------------------------
    // commit strobe
    // ------------------------------------------------------------
    reg         commit_reg;
    wire        strobe_fall;

    assign strobe_fall = strobe_prev_reg & ~strobe_sync_reg[1];

    // the key is sampled at the falling edge; settings must already be loaded
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            commit_reg <= 1'b0;
        else
            commit_reg <= strobe_fall & unlocked;
    end

    // ------------------------------------------------------------
    // volatile cfg registers and nvm image
    // ------------------------------------------------------------
    wire [79:0] cfg_flat;
    wire [79:0] nvm_flat;

    genvar g;
    generate
        for (g = 0; g < `CNPG_CFG_BYTES; g = g + 1) begin : gen_byte
            reg  [7:0] cfg_q;
            reg  [7:0] nvm_q;
            always @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b)
                    cfg_q <= `CNPG_CFG_RESET;
                else if (bus_wr_stb && bus_addr == `CNPG_CFG_FIRST + g)
                    cfg_q <= bus_wr_data;
            end
            always @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b)
                    nvm_q <= `CNPG_CFG_RESET;
                else if (commit_reg)
                    nvm_q <= cfg_q;
            end
            assign cfg_flat[g*8 +: 8] = cfg_q;
            assign nvm_flat[g*8 +: 8] = nvm_q;
        end
    endgenerate

    // trim byte is factory content; the programming path never writes it
    reg  [7:0]  trim_reg;
    reg  [7:0]  parity_reg;
    wire [7:0]  parity_seen;
    wire        parity_bad;

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            trim_reg <= `CNPG_TRIM_RESET;
        else
            trim_reg <= trim_reg;
    end

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            parity_reg <= `CNPG_PARITY_RESET;
        else if (commit_reg)
            parity_reg <= column_parity({trim_reg, cfg_flat});
    end

    assign parity_seen = parity_reg ^ upset_sync_reg;
    // compare is skipped during commit, when image and parity change on the same edge
    assign parity_bad  = ~commit_reg
                         & (column_parity({trim_reg, nvm_flat}) != parity_seen);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    integer idx;
    always @* begin
        bus_rd_data = 8'h00;
        idx = 0;
        if (in_cfg_range(bus_addr)) begin
            idx = bus_addr - `CNPG_CFG_FIRST;
            if (preread)
                bus_rd_data = nvm_flat[idx*8 +: 8];
            else
                bus_rd_data = cfg_flat[idx*8 +: 8];
        end else if (bus_addr == `CNPG_KEY_OFFSET) begin
            bus_rd_data = key_reg;
        end
    end

    // ------------------------------------------------------------
    // fail-safe fet drive
    // ------------------------------------------------------------
    // the fault latches until reset, so a flickering cell cannot re-enable the fets
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_parity_fault        <= 1'b0;
            o_discharge_fet_drive <= 1'b0;
            o_charge_fet_drive    <= 1'b0;
            o_nvm_config          <= 80'h0;
        end else begin
            o_parity_fault        <= o_parity_fault | parity_bad;
            o_discharge_fet_drive <= i_discharge_request & ~o_parity_fault & ~parity_bad;
            o_charge_fet_drive    <= i_charge_request & ~o_parity_fault & ~parity_bad;
            o_nvm_config          <= nvm_flat;
        end
    end

endmodule

// ---- bench/cnpg_top_monitor.sv ----
// Purpose : concurrent checks on the ports of the nvm program guard
// Assumes : bound to cnpg_top, one clock, async active-low reset
// Notes   : commit latency is taken as at most ten clocks after the strobe falls
`timescale 1ns/1ps
module cnpg_top_monitor (
    input logic        i_clk,
    input logic        i_rst_b,
    input logic        i_serial_access_enable_pin,
    input logic        i_serial_clock_pin,
    input logic        i_serial_data_pin,
    input logic        i_nvm_write_strobe_pin,
    input logic [7:0]  i_nvm_upset_mask,
    input logic        i_discharge_request,
    input logic        i_charge_request,
    input logic        o_serial_data_pin,
    input logic        o_serial_data_oe,
    input logic        o_discharge_fet_drive,
    input logic        o_charge_fet_drive,
    input logic        o_parity_fault,
    input logic [79:0] o_nvm_config
);
    // ------------------------------------------------------------
    // clocks elapsed since the strobe pin last fell
    // ------------------------------------------------------------
    logic       strobe_q;
    logic [3:0] since_fall;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strobe_q   <= 1'b0;
            since_fall <= 4'hF;
        end else begin
            strobe_q <= i_nvm_write_strobe_pin;
            if (strobe_q && !i_nvm_write_strobe_pin)
                since_fall <= 4'h0;
            else if (since_fall != 4'hF)
                since_fall <= since_fall + 4'h1;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_fault_kills_fets: assert property (o_parity_fault && $past(o_parity_fault)
        |-> !o_discharge_fet_drive && !o_charge_fet_drive) else $error("fet on during fault");
    a_dsg_follows_req: assert property ($past(i_rst_b) && !o_parity_fault
        |-> o_discharge_fet_drive == $past(i_discharge_request)) else $error("discharge drive");
    a_chg_follows_req: assert property ($past(i_rst_b) && !o_parity_fault
        |-> o_charge_fet_drive == $past(i_charge_request)) else $error("charge drive");
    a_fault_stays_set: assert property (o_parity_fault |=> o_parity_fault)
        else $error("fault cleared without reset");
    a_fault_has_cause: assert property ((i_nvm_upset_mask == 8'h00) [*8]
        |=> !$rose(o_parity_fault)) else $error("fault without parity upset");
    a_upset_trips_fault: assert property (i_nvm_upset_mask != 8'h00
        |-> ##[0:8] o_parity_fault) else $error("parity upset not caught");
    a_commit_after_strobe: assert property ($changed(o_nvm_config)
        |-> since_fall <= 4'hA) else $error("nvm changed without strobe fall");
    a_port_idle_disabled: assert property (!i_serial_access_enable_pin [*5]
        |-> !o_serial_data_oe) else $error("sda driven while port disabled");
    c_commit: cover property ($changed(o_nvm_config));
    c_fault: cover property ($rose(o_parity_fault));
    c_ack: cover property ($rose(o_serial_data_oe));
endmodule

bind cnpg_top cnpg_top_monitor u_monitor (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_serial_access_enable_pin(i_serial_access_enable_pin),
    .i_serial_clock_pin(i_serial_clock_pin), .i_serial_data_pin(i_serial_data_pin),
    .i_nvm_write_strobe_pin(i_nvm_write_strobe_pin), .i_nvm_upset_mask(i_nvm_upset_mask),
    .i_discharge_request(i_discharge_request), .i_charge_request(i_charge_request),
    .o_serial_data_pin(o_serial_data_pin), .o_serial_data_oe(o_serial_data_oe),
    .o_discharge_fet_drive(o_discharge_fet_drive), .o_charge_fet_drive(o_charge_fet_drive),
    .o_parity_fault(o_parity_fault), .o_nvm_config(o_nvm_config));

// ---- bench/cnpg_i2c_prog.sv ----
// Purpose : behavioural i2c programmer on the far side of the serial port
// Assumes : sda has a pull-up, resolved by the bench; moves only on falling clk edges
// Notes   : scl high phase lasts eight clocks, low phase sixteen, scl stands high between frames
`timescale 1ns/1ps
`include "cnpg_defines.vh"
module cnpg_i2c_prog (
    input  logic i_clk,
    input  logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    initial begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic hold();
        repeat (8) @(negedge i_clk);
    endtask
    // also serves as repeated start, entered with scl low
    task automatic start();
        o_sda_oe = 1'b0;
        hold();
        o_scl = 1'b1;
        hold();
        o_sda_oe = 1'b1;
        hold();
        o_scl = 1'b0;
        hold();
    endtask
    task automatic stop();
        o_sda_oe = 1'b1;
        hold();
        o_scl = 1'b1;
        hold();
        o_sda_oe = 1'b0;
        hold();
    endtask
    // sda only moves eight clocks after scl fell, half way through the low phase, so no false start or stop
    task automatic xbit(input logic b, output logic r);
        o_sda_oe = !b;
        hold();
        o_scl = 1'b1;
        hold();
        r = i_sda;
        o_scl = 1'b0;
        hold();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        wbyte({`CNPG_DEV_ADDR, 1'b0}, a0);
        wbyte(p, a1);
        wbyte(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic a0, a1, a2, r;
        start();
        wbyte({`CNPG_DEV_ADDR, 1'b0}, a0);
        wbyte(p, a1);
        start();
        wbyte({`CNPG_DEV_ADDR, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(1'b1, r);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

// ---- bench/cnpg_bench.sv ----
// Purpose : self-checking bench of the nvm program guard
// Assumes : inputs move on falling clk edges, sda resolved with a pull-up
// Notes   : random cfg bytes and fet requests from a fixed-seed lfsr
`timescale 1ns/1ps
`include "cnpg_defines.vh"
module cnpg_bench;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        en_pin = 1'b1;
    logic        strobe_pin = 1'b0;
    logic [7:0]  upset = 8'h00;
    logic        dsg_req = 1'b0;
    logic        chg_req = 1'b0;
    logic        scl, prog_oe, sda_out, dut_oe, discharge_fet_drive, charge_fet_drive, fault, ok;
    logic [79:0] nvm;
    wire         sda = !(prog_oe || dut_oe);
    logic [31:0] seed = 32'h3458B0E7;
    logic [7:0]  cfg [10];
    logic [7:0]  bad_keys [5];
    logic [7:0]  rdat;
    int          bad_count = 0;
    int          n_tests = 0;

    always #5 i_clk = !i_clk;
    cnpg_top dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_serial_access_enable_pin(en_pin),
        .i_serial_clock_pin(scl), .i_serial_data_pin(sda), .i_nvm_write_strobe_pin(strobe_pin),
        .i_nvm_upset_mask(upset), .i_discharge_request(dsg_req), .i_charge_request(chg_req),
        .o_serial_data_pin(sda_out), .o_serial_data_oe(dut_oe), .o_discharge_fet_drive(discharge_fet_drive),
        .o_charge_fet_drive(charge_fet_drive), .o_parity_fault(fault), .o_nvm_config(nvm));
    cnpg_i2c_prog prog (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(prog_oe));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [79:0] image();
        logic [79:0] v;
        for (int k = 0; k < 10; k++) v[8*k +: 8] = cfg[k];
        return v;
    endfunction
    task automatic chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        prog.wr(p, d, ok);
        chk("write ack", ok, 1'b1);
    endtask
    task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
        prog.rd(p, rdat, ok);
        chk("read data", {ok, rdat}, {1'b1, e});
    endtask
    // strobe pulse high then low, then room for the commit to land
    task automatic commit();
        strobe_pin = 1'b1;
        repeat (8) @(negedge i_clk);
        strobe_pin = 1'b0;
        repeat (12) @(negedge i_clk);
    endtask

    initial begin
        repeat (20) @(negedge i_clk);
        i_rst_b = 1'b1;
        repeat (4) @(negedge i_clk);
        chk("nvm after reset", nvm, 80'h0);
        chk("sda output level", sda_out, 1'b0);
        rd_chk(`CNPG_KEY_OFFSET, `CNPG_KEY_RESET);
        for (int k = 0; k < 10; k++) begin
            seed = lfsr(seed);
            cfg[k] = {seed[7:1], 1'b1};
            wr(`CNPG_CFG_FIRST + k[7:0], cfg[k]);
        end
        $display("test reset and load done");
        bad_keys = '{8'h00, 8'h40, 8'h42, `CNPG_KEY_PREREAD, {seed[15:9], 1'b0}};
        foreach (bad_keys[i]) begin
            wr(`CNPG_KEY_OFFSET, bad_keys[i]);
            commit();
            chk("nvm locked", nvm, 80'h0);
        end
        wr(`CNPG_KEY_OFFSET, `CNPG_KEY_PREREAD);
        rd_chk(`CNPG_CFG_FIRST, 8'h00);
        wr(`CNPG_KEY_OFFSET, `CNPG_KEY_RESET);
        rd_chk(`CNPG_CFG_LAST, cfg[9]);
        $display("test locked keys done");
        wr(`CNPG_KEY_OFFSET, `CNPG_KEY_UNLOCK);
        strobe_pin = 1'b1;
        repeat (20) @(negedge i_clk);
        chk("nvm while strobe high", nvm, 80'h0);
        strobe_pin = 1'b0;
        repeat (12) @(negedge i_clk);
        chk("nvm after commit", nvm, image());
        chk("parity after commit", fault, 1'b0);
        wr(`CNPG_CFG_LAST, ~cfg[9]);
        wr(8'h0C, 8'h5A);
        wr(`CNPG_KEY_OFFSET, `CNPG_KEY_PREREAD);
        rd_chk(`CNPG_CFG_FIRST, cfg[0]);
        rd_chk(`CNPG_CFG_LAST, cfg[9]);
        rd_chk(8'h0C, 8'h00);
        $display("test commit and pre-read done");
        en_pin = 1'b0;
        repeat (6) @(negedge i_clk);
        prog.wr(`CNPG_KEY_OFFSET, `CNPG_KEY_UNLOCK, ok);
        chk("ack while disabled", ok, 1'b0);
        en_pin = 1'b1;
        repeat (6) @(negedge i_clk);
        rd_chk(`CNPG_KEY_OFFSET, `CNPG_KEY_PREREAD);
        $display("test access enable done");
        for (int n = 0; n < 64; n++) begin
            {dsg_req, chg_req} = seed[1:0];
            seed = lfsr(seed);
            @(negedge i_clk);
            chk("fet drives", {discharge_fet_drive, charge_fet_drive}, {dsg_req, chg_req});
        end
        dsg_req = 1'b1;
        chg_req = 1'b1;
        upset = {seed[7:1], 1'b1};
        repeat (10) @(negedge i_clk);
        chk("fault on upset", fault, 1'b1);
        upset = 8'h00;
        repeat (10) @(negedge i_clk);
        chk("fets forced off", {fault, discharge_fet_drive, charge_fet_drive}, 3'h4);
        $display("test parity fail-safe done");
        i_rst_b = 1'b0;
        repeat (3) @(negedge i_clk);
        i_rst_b = 1'b1;
        repeat (4) @(negedge i_clk);
        chk("fault after reset", fault, 1'b0);
        chk("nvm after reset", nvm, 80'h0);
        $display("test second reset done");
        end_sim();
    end

    initial begin
        #400_000;
        bad_count++;
        end_sim();
    end
endmodule
